// [logic/cpd_pkg.sv]
package cpd_pkg;

  // register byte addresses
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_WAKE   = 8'h08;

  // control register bit positions
  localparam int CTRL_RECOVERY_BIT  = 0;
  localparam int CTRL_THRESHOLD_BIT = 1;
  localparam int CTRL_SEL_WAKE_BIT  = 2;
  localparam int CTRL_BIAS_BIT      = 3;
  localparam int CTRL_SUPPLY_BIT    = 4;
  localparam int CTRL_EMUL_BIT      = 5;
  localparam int CTRL_EN_LEVEL_BIT  = 6;

  // status register fields
  localparam int STAT_CODE_LSB    = 0;
  localparam int STAT_OFFSET_BIT  = 4;
  localparam int STAT_TX_EN_BIT   = 5;
  localparam int STAT_PATTERN_BIT = 6;

  // wake register bits, write one to clear
  localparam int WAKE_CAN_BIT    = 0;
  localparam int WAKE_LIN_BIT    = 1;
  localparam int WAKE_PIN_BIT    = 2;
  localparam int WAKE_ONLINE_BIT = 3;

  // reset values
  localparam logic [6:0] CTRL_RESET   = 7'h00;
  localparam logic [3:0] WAKE_RESET   = 4'h0;
  localparam logic       OFFSET_RESET = 1'b0;

  // failure codes; local interface faults outrank bus faults
  localparam logic [3:0] CODE_NONE    = 4'h0;
  localparam logic [3:0] CODE_TXD_DOM = 4'h1;
  localparam logic [3:0] CODE_RXD_DOM = 4'h2;
  localparam logic [3:0] CODE_RXD_REC = 4'h3;

  // recessive time before a ground offset refresh
  localparam int CLK_PERIOD_NS = 20;
  localparam int REC_TIME_NS   = 80000;
  localparam int REC_CYCLES    = REC_TIME_NS / CLK_PERIOD_NS;

endpackage : cpd_pkg

// [logic/cpd_recessive_timer.sv]
module cpd_recessive_timer #(
  parameter int CYCLES = cpd_pkg::REC_CYCLES,
  parameter int CW     = 12
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic active_in,
  input  wire logic recessive_in,
  output logic      refresh_out
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          refresh;
  } cpd_timer_s;

  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  cpd_timer_s st_r;
  cpd_timer_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.refresh = 1'b0;
    // any dominant bit or leaving active mode restarts the wait
    if (!active_in || !recessive_in) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == LAST) begin
      st_nxt.cnt = '0;
      st_nxt.refresh = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign refresh_out = st_r.refresh;

endmodule : cpd_recessive_timer

// [logic/cpd_top.sv]
// Notes on behaviour
// - forced recovery with fault still present: fault re-detected, transmitter off again
// - ground offset flag shows result; every change gives an event pulse
// - ground offset refreshed after about 80 us recessive in active mode
// - outside active mode ground offset diagnosis stops, flag frozen
// - threshold select picks normal or increased threshold; normal after reset
// - emulation mode: enable pin high only while failure code is none
// - emulation select set by writing 1, only in start-up or restart
// - selective wake: outside on-line listen, CAN wakes only on initial then global pattern
// - LIN wake and wake input stay active with selective wake set
// - same fixed patterns for all nodes; no single node wake
// - bias select 1 drives recessive level on split pin, else float
// - split pin off without secondary supply or while CAN off-line
// - recovery bit set then cleared resets failure code and enables transmitter
// - txd dominant or rxd recessive disables transmitter until recovery or rx activity clears the latch
// - global pattern in on-line listen: go on-line and raise CAN wake
module cpd_top (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // wishbone classic slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // transceiver and system state
  input  wire logic        can_active_in,
  input  wire logic        can_offline_in,
  input  wire logic        online_listen_in,
  input  wire logic        startup_or_restart_in,
  input  wire logic        secondary_supply_ok_in,
  input  wire logic        bus_recessive_in,
  input  wire logic        rx_activity_in,
  // analog detectors
  input  wire logic        offset_normal_in,
  input  wire logic        offset_increased_in,
  input  wire logic        txd_dominant_fault_in,
  input  wire logic        rxd_dominant_fault_in,
  input  wire logic        rxd_recessive_fault_in,
  input  wire logic [3:0]  bus_failure_code_in,
  // wake sources
  input  wire logic        conventional_wake_in,
  input  wire logic        initial_pattern_in,
  input  wire logic        global_pattern_in,
  input  wire logic        lin_wake_in,
  input  wire logic        wake_pin_in,
  // outputs
  output logic             can_tx_enable_out,
  output logic             enable_pin_out,
  output logic             secondary_supply_enable_out,
  output logic             split_drive_out,
  output logic             split_oe_n_out,
  output logic             offset_change_out,
  output logic             can_wake_out,
  output logic             goto_online_out
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        recovery;
    logic        threshold;
    logic        sel_wake;
    logic        bias;
    logic        supply;
    logic        emul;
    logic        en_level;
    logic        txd_lat;
    logic        rxd_lat;
    logic [3:0]  code;
    logic        offset_flag;
    logic        offset_chg;
    logic        initial_seen;
    logic [3:0]  wake_st;
    logic        can_wake;
    logic        goto_online;
    logic        tx_en;
    logic        en_pin;
    logic        split_drv;
    logic        split_oe_n;
  } cpd_state_s;

  cpd_state_s st_r;
  cpd_state_s st_nxt;
  logic       refresh;

  cpd_recessive_timer #(
    .CYCLES (cpd_pkg::REC_CYCLES),
    .CW     (12)
  ) u_rec_timer (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .active_in    (can_active_in),
    .recessive_in (bus_recessive_in),
    .refresh_out  (refresh)
  );

  logic       req;
  logic       wr0;
  logic       recov;
  logic       sample;
  logic       pattern_wake;
  logic [3:0] wake_set;
  logic [3:0] wake_clr;

  always_comb begin
    st_nxt = st_r;
    req = wb_cyc_in && wb_stb_in && !st_r.ack;
    wr0 = req && wb_we_in && wb_sel_in[0];
    recov = 1'b0;
    wake_clr = '0;

    // bus answer: ack one cycle after the request, dropped the next cycle
    st_nxt.ack = req;
    st_nxt.rdata = '0;
    if (req && !wb_we_in) begin
      unique case (wb_adr_in)
        cpd_pkg::ADR_CTRL: begin
          st_nxt.rdata[cpd_pkg::CTRL_RECOVERY_BIT]  = st_r.recovery;
          st_nxt.rdata[cpd_pkg::CTRL_THRESHOLD_BIT] = st_r.threshold;
          st_nxt.rdata[cpd_pkg::CTRL_SEL_WAKE_BIT]  = st_r.sel_wake;
          st_nxt.rdata[cpd_pkg::CTRL_BIAS_BIT]      = st_r.bias;
          st_nxt.rdata[cpd_pkg::CTRL_SUPPLY_BIT]    = st_r.supply;
          st_nxt.rdata[cpd_pkg::CTRL_EMUL_BIT]      = st_r.emul;
          st_nxt.rdata[cpd_pkg::CTRL_EN_LEVEL_BIT]  = st_r.en_level;
        end
        cpd_pkg::ADR_STATUS: begin
          st_nxt.rdata[cpd_pkg::STAT_CODE_LSB +: 4]  = st_r.code;
          st_nxt.rdata[cpd_pkg::STAT_OFFSET_BIT]     = st_r.offset_flag;
          st_nxt.rdata[cpd_pkg::STAT_TX_EN_BIT]      = st_r.tx_en;
          st_nxt.rdata[cpd_pkg::STAT_PATTERN_BIT]    = st_r.initial_seen;
        end
        cpd_pkg::ADR_WAKE: begin
          st_nxt.rdata[3:0] = st_r.wake_st;
        end
        default: st_nxt.rdata = '0;
      endcase
    end

    if (wr0 && wb_adr_in == cpd_pkg::ADR_CTRL) begin
      // recovery fires on the write that clears a previously set bit
      recov = st_r.recovery && !wb_dat_in[cpd_pkg::CTRL_RECOVERY_BIT];
      st_nxt.recovery  = wb_dat_in[cpd_pkg::CTRL_RECOVERY_BIT];
      st_nxt.threshold = wb_dat_in[cpd_pkg::CTRL_THRESHOLD_BIT];
      st_nxt.sel_wake  = wb_dat_in[cpd_pkg::CTRL_SEL_WAKE_BIT];
      st_nxt.bias      = wb_dat_in[cpd_pkg::CTRL_BIAS_BIT];
      st_nxt.supply    = wb_dat_in[cpd_pkg::CTRL_SUPPLY_BIT];
      st_nxt.en_level  = wb_dat_in[cpd_pkg::CTRL_EN_LEVEL_BIT];
      if (startup_or_restart_in) begin
        st_nxt.emul = wb_dat_in[cpd_pkg::CTRL_EMUL_BIT];
      end
    end
    if (wr0 && wb_adr_in == cpd_pkg::ADR_WAKE) begin
      wake_clr = wb_dat_in[3:0];
    end

    // latched interface faults; detection outranks any clear so a forced
    // recovery with the fault still present re-disables at once
    st_nxt.txd_lat = txd_dominant_fault_in ||
                     (st_r.txd_lat && !recov && !rx_activity_in);
    st_nxt.rxd_lat = rxd_recessive_fault_in ||
                     (st_r.rxd_lat && !recov && !rx_activity_in);
    st_nxt.tx_en = !(st_nxt.txd_lat || st_nxt.rxd_lat);

    if (st_nxt.txd_lat) begin
      st_nxt.code = cpd_pkg::CODE_TXD_DOM;
    end else if (rxd_dominant_fault_in) begin
      st_nxt.code = cpd_pkg::CODE_RXD_DOM;
    end else if (st_nxt.rxd_lat) begin
      st_nxt.code = cpd_pkg::CODE_RXD_REC;
    end else if (recov) begin
      st_nxt.code = cpd_pkg::CODE_NONE;
    end else begin
      st_nxt.code = bus_failure_code_in;
    end

    // ground offset: sampled only on refresh, which needs active mode
    sample = refresh && can_active_in;
    st_nxt.offset_chg = 1'b0;
    if (sample) begin
      st_nxt.offset_flag = st_r.threshold ? offset_increased_in
                                          : offset_normal_in;
      st_nxt.offset_chg = st_nxt.offset_flag != st_r.offset_flag;
    end

    // emulated error pin tracks the code so it drops in the same cycle
    st_nxt.en_pin = st_nxt.emul ? (st_nxt.code == cpd_pkg::CODE_NONE)
                                : st_nxt.en_level;

    // fixed patterns with no node address: every armed node wakes alike
    if (initial_pattern_in) begin
      st_nxt.initial_seen = 1'b1;
    end
    pattern_wake = global_pattern_in && (st_r.initial_seen || initial_pattern_in);
    if (pattern_wake) begin
      st_nxt.initial_seen = 1'b0;
    end
    st_nxt.can_wake = st_r.sel_wake ? pattern_wake
                                    : (conventional_wake_in || pattern_wake);
    // listen mode reacts to the global pattern alone, no initial needed
    st_nxt.goto_online = online_listen_in && global_pattern_in;
    if (st_nxt.goto_online) begin
      st_nxt.can_wake = 1'b1;
    end

    wake_set = '0;
    wake_set[cpd_pkg::WAKE_CAN_BIT]    = st_nxt.can_wake;
    wake_set[cpd_pkg::WAKE_LIN_BIT]    = lin_wake_in;
    wake_set[cpd_pkg::WAKE_PIN_BIT]    = wake_pin_in;
    wake_set[cpd_pkg::WAKE_ONLINE_BIT] = st_nxt.goto_online;
    // a new event beats a clear in the same cycle
    st_nxt.wake_st = wake_set | (st_r.wake_st & ~wake_clr);

    // split pin is fed from the secondary supply, so it needs it up
    st_nxt.split_drv = st_nxt.bias && secondary_supply_ok_in &&
                       !can_offline_in;
    st_nxt.split_oe_n = !st_nxt.split_drv;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r              <= '0;
      st_r.threshold    <= cpd_pkg::CTRL_RESET[cpd_pkg::CTRL_THRESHOLD_BIT];
      st_r.emul         <= cpd_pkg::CTRL_RESET[cpd_pkg::CTRL_EMUL_BIT];
      st_r.offset_flag  <= cpd_pkg::OFFSET_RESET;
      st_r.wake_st      <= cpd_pkg::WAKE_RESET;
      st_r.code         <= cpd_pkg::CODE_NONE;
      st_r.tx_en        <= 1'b1;
      st_r.split_oe_n   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_out                  = st_r.rdata;
  assign wb_ack_out                  = st_r.ack;
  assign can_tx_enable_out           = st_r.tx_en;
  assign enable_pin_out              = st_r.en_pin;
  assign secondary_supply_enable_out = st_r.supply;
  assign split_drive_out             = st_r.split_drv;
  assign split_oe_n_out              = st_r.split_oe_n;
  assign offset_change_out           = st_r.offset_chg;
  assign can_wake_out                = st_r.can_wake;
  assign goto_online_out             = st_r.goto_online;

endmodule : cpd_top

// [dv/cpd_can_nodes.sv]
module cpd_can_nodes (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       go_in,
  input  wire logic [1:0] kind_in,
  output logic            bus_recessive_out,
  output logic            rx_activity_out,
  output logic            conventional_wake_out,
  output logic            initial_pattern_out,
  output logic            global_pattern_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // one dominant frame cycle per message; bus idles recessive between them
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_recessive_out     <= 1'b1;
      rx_activity_out       <= 1'b0;
      conventional_wake_out <= 1'b0;
      initial_pattern_out   <= 1'b0;
      global_pattern_out    <= 1'b0;
    end else begin
      bus_recessive_out     <= !go_in;
      rx_activity_out       <= go_in;
      conventional_wake_out <= go_in && kind_in == 2'h0;
      initial_pattern_out   <= go_in && kind_in == 2'h1;
      global_pattern_out    <= go_in && kind_in == 2'h2;
    end
  end
endmodule : cpd_can_nodes

// [dv/cpd_top_asserts.sv]
module cpd_top_asserts (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        can_active_in,
  input wire logic        can_offline_in,
  input wire logic        online_listen_in,
  input wire logic        secondary_supply_ok_in,
  input wire logic        global_pattern_in,
  input wire logic        txd_dominant_fault_in,
  input wire logic        rxd_recessive_fault_in,
  input wire logic        can_tx_enable_out,
  input wire logic        split_drive_out,
  input wire logic        split_oe_n_out,
  input wire logic        offset_change_out,
  input wire logic        goto_online_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing after request");
  chk_ack_pulse: assert property ($rose(wb_ack_out) |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data not zero without ack");
  chk_txd_off: assert property (txd_dominant_fault_in |=> !can_tx_enable_out)
    else $error("transmitter on with txd fault");
  chk_rxd_off: assert property (rxd_recessive_fault_in |=> !can_tx_enable_out)
    else $error("transmitter on with rxd fault");
  chk_split_supply: assert property (!secondary_supply_ok_in || can_offline_in |=> !split_drive_out)
    else $error("split driven without supply");
  chk_split_oe: assert property (split_oe_n_out == !split_drive_out)
    else $error("split enable disagrees with drive");
  chk_offset_frozen: assert property ((!can_active_in) [*4] |=> !offset_change_out)
    else $error("offset changed outside active mode");
  chk_online_go: assert property (online_listen_in && global_pattern_in |=> goto_online_out)
    else $error("no on-line move on global pattern");
  cov_split: cover property (split_drive_out);
  cov_offset: cover property (offset_change_out);
  cov_online: cover property (goto_online_out);
endmodule : cpd_top_asserts

bind cpd_top cpd_top_asserts cpd_top_asserts_i (.clk_in, .rst_in, .wb_cyc_in, .wb_stb_in,
  .wb_dat_out, .wb_ack_out, .can_active_in, .can_offline_in, .online_listen_in,
  .secondary_supply_ok_in, .global_pattern_in, .txd_dominant_fault_in, .rxd_recessive_fault_in,
  .can_tx_enable_out, .split_drive_out, .split_oe_n_out, .offset_change_out, .goto_online_out);

// [dv/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in, rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, go;
  logic [7:0]  wb_adr_in;
  logic [3:0]  wb_sel_in, bus_failure_code_in, code;
  logic [31:0] wb_dat_in, wb_dat_out;
  logic [1:0]  kind;
  logic can_active_in, can_offline_in, online_listen_in, startup_or_restart_in;
  logic secondary_supply_ok_in, offset_normal_in, offset_increased_in, lin_wake_in;
  logic txd_dominant_fault_in, rxd_dominant_fault_in, rxd_recessive_fault_in, wake_pin_in;
  logic bus_recessive_in, rx_activity_in, conventional_wake_in, initial_pattern_in;
  logic global_pattern_in, can_tx_enable_out, enable_pin_out, secondary_supply_enable_out;
  logic split_drive_out, split_oe_n_out, offset_change_out, can_wake_out, goto_online_out;
  logic [63:0] expq[$];
  int          n_errors, total_checks, n_change, n_wake;

  cpd_top cpd_top_i (.*);
  cpd_can_nodes cpd_can_nodes_i (.clk_in, .rst_in, .go_in(go), .kind_in(kind),
    .bus_recessive_out(bus_recessive_in), .rx_activity_out(rx_activity_in),
    .conventional_wake_out(conventional_wake_in), .initial_pattern_out(initial_pattern_in),
    .global_pattern_out(global_pattern_in));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // reads queue {mask, expected}; the monitor below compares at ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    if (!w) expq.push_back({m, d});
    @(posedge clk_in);
    wb_cyc_in <= 1'b1; wb_stb_in <= 1'b1; wb_we_in <= w; wb_adr_in <= a; wb_dat_in <= d;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      conclude();
    end
    wb_cyc_in <= 1'b0; wb_stb_in <= 1'b0;
  endtask : wb

  task automatic send(input logic [1:0] k);
    @(posedge clk_in);
    go <= 1'b1; kind <= k;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask : send

  always @(posedge clk_in) begin
    logic [63:0] e;
    if (offset_change_out === 1'b1) n_change++;
    if (can_wake_out === 1'b1) n_wake++;
    if (wb_ack_out === 1'b1 && wb_we_in === 1'b0) begin
      e = expq.pop_front();
      chk("read", wb_dat_out & e[63:32], e[31:0]);
    end
  end

  initial begin
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in, go, kind, bus_failure_code_in} = '0;
    {can_active_in, can_offline_in, online_listen_in, startup_or_restart_in} = '0;
    {secondary_supply_ok_in, offset_normal_in, offset_increased_in, lin_wake_in} = '0;
    {txd_dominant_fault_in, rxd_dominant_fault_in, rxd_recessive_fault_in, wake_pin_in} = '0;
    wb_sel_in = 4'hf; rst_in = 1'b1; n_errors = 0; total_checks = 0; n_change = 0;
    n_wake = 0;
    void'($urandom(64009));
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    wb(0, cpd_pkg::ADR_CTRL, 32'h0, '1);
    wb(0, cpd_pkg::ADR_STATUS, 32'h20, '1);
    wb(0, 8'h0c, 32'h0, '1);
    for (int i = 1; i < 4; i++) begin
      {rxd_recessive_fault_in, rxd_dominant_fault_in, txd_dominant_fault_in} <= 3'(1 << (i - 1));
      wb(0, cpd_pkg::ADR_STATUS, (i == 2) ? 32'h22 : 32'(i), '1);
      {rxd_recessive_fault_in, rxd_dominant_fault_in, txd_dominant_fault_in} <= 3'h0;
      send(2'h0);
      wb(0, cpd_pkg::ADR_STATUS, 32'h20, '1);
    end
    txd_dominant_fault_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    txd_dominant_fault_in <= 1'b0;
    wb(1, cpd_pkg::ADR_CTRL, 32'h1, '0);
    wb(1, cpd_pkg::ADR_CTRL, 32'h0, '0);
    wb(0, cpd_pkg::ADR_STATUS, 32'h20, '1);
    txd_dominant_fault_in <= 1'b1;
    wb(1, cpd_pkg::ADR_CTRL, 32'h1, '0);
    wb(1, cpd_pkg::ADR_CTRL, 32'h0, '0);
    wb(0, cpd_pkg::ADR_STATUS, 32'h1, '1);
    txd_dominant_fault_in <= 1'b0;
    send(2'h0);
    startup_or_restart_in <= 1'b1;
    wb(1, cpd_pkg::ADR_CTRL, 32'h20, '0);
    startup_or_restart_in <= 1'b0;
    wb(1, cpd_pkg::ADR_CTRL, 32'h0, '0);
    wb(0, cpd_pkg::ADR_CTRL, 32'h20, '1);
    chk("en_pin", 32'(enable_pin_out), 32'h1);
    code = 4'(4 + $urandom_range(11));
    bus_failure_code_in <= code;
    repeat (3) @(posedge clk_in);
    chk("en_pin", 32'(enable_pin_out), 32'h0);
    wb(0, cpd_pkg::ADR_STATUS, 32'(code), 32'hf);
    bus_failure_code_in <= 4'h0;
    offset_normal_in <= 1'b1; can_active_in <= 1'b1; n_change = 0;
    repeat (3990) @(posedge clk_in);
    chk("en_pin", 32'(enable_pin_out), 32'h1);
    wb(0, cpd_pkg::ADR_STATUS, 32'h0, 32'h10);
    repeat (20) @(posedge clk_in);
    wb(0, cpd_pkg::ADR_STATUS, 32'h10, 32'h10);
    chk("changes", n_change, 32'h1);
    wb(1, cpd_pkg::ADR_CTRL, 32'h2, '0);
    repeat (4010) @(posedge clk_in);
    wb(0, cpd_pkg::ADR_STATUS, 32'h0, 32'h10);
    can_active_in <= 1'b0; offset_increased_in <= 1'b1;
    repeat (4100) @(posedge clk_in);
    wb(0, cpd_pkg::ADR_STATUS, 32'h0, 32'h10);
    chk("changes", n_change, 32'h2);
    {secondary_supply_ok_in, can_offline_in} <= 2'h2;
    repeat (2) @(posedge clk_in);
    chk("split", 32'(split_drive_out), 32'h0);
    wb(1, cpd_pkg::ADR_CTRL, 32'h18, '0);
    chk("supply", 32'(secondary_supply_enable_out), 32'h1);
    for (int i = 0; i < 4; i++) begin
      {secondary_supply_ok_in, can_offline_in} <= 2'(i);
      repeat (2) @(posedge clk_in);
      chk("split", 32'(split_drive_out), 32'(i == 2));
      chk("split_oe_n", 32'(split_oe_n_out), 32'(i != 2));
    end
    // sel wake armed before clearing, so stale traffic wakes do not linger
    wb(1, cpd_pkg::ADR_CTRL, 32'h4, '0);
    chk("supply", 32'(secondary_supply_enable_out), 32'h0);
    n_wake = 0;
    wb(1, cpd_pkg::ADR_WAKE, 32'hf, '0);
    send(2'h0);
    wb(0, cpd_pkg::ADR_WAKE, 32'h0, '1);
    lin_wake_in <= 1'b1; wake_pin_in <= 1'b1;
    @(posedge clk_in);
    lin_wake_in <= 1'b0; wake_pin_in <= 1'b0;
    wb(0, cpd_pkg::ADR_WAKE, 32'h6, '1);
    wb(1, cpd_pkg::ADR_WAKE, 32'hf, '0);
    send(2'h1);
    send(2'h2);
    wb(0, cpd_pkg::ADR_WAKE, 32'h1, 32'h1);
    online_listen_in <= 1'b1;
    send(2'h2);
    wb(0, cpd_pkg::ADR_WAKE, 32'h8, 32'h8);
    chk("wakes", n_wake, 32'h2);
    conclude();
  end
endmodule : tb
